// ### sl_params.svh
// constants for the status indicator and progress code display
// assumes a 100 MHz core clock and a 32-bit plain register port
`ifndef SL_PARAMS_SVH
`define SL_PARAMS_SVH

// register offsets (byte addresses)
`define SL_OFS_CFG        8'h00
`define SL_OFS_POST       8'h04
`define SL_OFS_STAT       8'h08

// configuration and progress code register fields and reset values
`define SL_CFG_LSB        0
`define SL_CFG_MSB        7
`define SL_CFG_RST        8'h20
`define SL_POST_LSB       0
`define SL_POST_MSB       7
`define SL_POST_RST       8'h00

// status register fields
`define SL_STAT_LED_LSB   0
`define SL_STAT_LED_MSB   2
`define SL_STAT_ID_POS    3
`define SL_STAT_GRN_POS   4
`define SL_STAT_AMB_POS   5

// memory count above which unusable memory counts as degraded
`define SL_MIN_DIMMS      4'h1
// memory count at which a module failure leaves no good memory
`define SL_ONLY_DIMM      4'h1

// timing: blink rates in hertz, counts are half periods in cycles
`define SL_CLK_HZ         100000000
`define SL_SLOW_BLINK_HZ  1
`define SL_FAST_BLINK_HZ  3
`define SL_SLOW_HALF_CYC  (`SL_CLK_HZ / (2 * `SL_SLOW_BLINK_HZ))
`define SL_FAST_HALF_CYC  (`SL_CLK_HZ / (2 * `SL_FAST_BLINK_HZ))

`endif

// ### sl_pkg.sv
// types for the status indicator and progress code display
// assumes sl_params.svh is compiled alongside
package sl_pkg;

  // indicator states, ordered by rising severity
  typedef enum logic [2:0] {
    st_off, st_green, st_green_blink, st_amber_blink, st_amber
  } sl_led_e;

  // identify indicator modes
  typedef enum logic [1:0] {id_off, id_blink, id_solid} sl_id_e;

  // configuration written by software
  typedef struct packed {
    logic [3:0] fan_min;
    logic       mirror_en;
    logic       spare_en;
    logic       fan_redund;
    logic       psu_redund;
  } sl_cfg_s;

  // register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sl_bus_s;

  // platform health conditions, active high levels except the counts fans_ok and dimm_count and the index spare_dimm
  typedef struct packed {
    logic       ac_present;
    logic       bmc_ready;
    logic       psu_redund_lost;
    logic       fan_redund_lost;
    logic       fan_fault;
    logic [3:0] fans_ok;
    logic [4:0] noncrit_thresh;
    logic       psu_predictive;
    logic       battery_fail;
    logic       mem_unusable;
    logic [3:0] dimm_count;
    logic       ce_spare_migrated;
    logic [2:0] spare_dimm;
    logic       mirror_lost;
    logic       bmc_bootloader;
    logic       bmc_os_boot;
    logic       bmc_wdt_reset;
    logic       pu_config_err;
    logic       drive_hot_swap_controller_degraded;
    logic [4:0] crit_thresh;
    logic       regulator_hot_flag;
    logic       drive_fault;
    logic       pu_insufficient;
    logic       ce_over_thresh;
    logic       processor_catastrophic_error;
    logic       processor_identity_mismatch;
    logic       cpu1_absent;
    logic       thermal_trip_flag;
    logic       power_good;
    logic       dimm_failed;
    logic       mem_uncorrectable;
    logic       mem_thermal_trip;
    logic       south_bridge_thermal_trip;
    logic       processor_second_error;
    logic       bmc_video_mem_fail;
    logic       fw_images_bad;
    logic       va240_fault;
  } sl_health_s;

endpackage

// ### sl_status_led.sv
// status indicator, identify indicator and progress code display
// assumes health levels synchronous to core_clk_i, bus per sl_bus_s
//
// Summary of operation
// - steady green when healthy, powered, controller booted
// - green blink on configured redundancy loss
// - green blink on fan fault above minimum
// - green blink on non-critical threshold crossing
// - green blink on predictive supply fail with supply redundancy configured, battery
// - green blink on unusable memory, several modules
// - green blink, lit module on sparing, mirror
// - bootloader stage: green blink, identify 3 Hz
// - controller OS boot: green blink, identify on
// - green blink on watchdog, config, hot-swap
// - amber blink on critical threshold crossing
// - amber blink on regulator hot, fans, drive
// - amber blink on too few power supplies
// - amber blink on unprotected correctable error excess
// - steady amber on processor fatal conditions
// - steady amber on power, memory, thermal faults
// - steady amber, identify on, firmware failures
// - code on eight indicators, bit 7 first
// - last code held until next write or reset

`include "sl_params.svh"

module sl_status_led
  import sl_pkg::*;
#(
  parameter int unsigned SLOW_HALF = `SL_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = `SL_FAST_HALF_CYC,
  parameter int unsigned DIMM_NUM  = 8
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  // register port
  input  wire sl_pkg::sl_bus_s      bus_i,
  output logic [31:0]               rdata_o,
  // platform health
  input  wire sl_pkg::sl_health_s   health_i,
  // indicators
  output logic                      status_green_o,
  output logic                      status_amber_o,
  output logic                      id_led_o,
  output logic [7:0]                post_leds_o,
  output logic [DIMM_NUM-1:0]       dimm_fault_o
);

  ////////////////////////////////////////////////////////////////
  // state of the block

  typedef struct packed {
    sl_cfg_s             cfg;
    logic [7:0]          post;
    logic [31:0]         slow_cnt;
    logic [31:0]         fast_cnt;
    logic                slow_ph;
    logic                fast_ph;
    sl_led_e             led;
    sl_id_e              id;
    logic                green;
    logic                amber;
    logic                id_on;
    logic [DIMM_NUM-1:0] dimm;
    logic [31:0]         rdata;
    logic                armed;
  } sl_state_s;

  sl_state_s st_reg;
  sl_state_s st_next;

  ////////////////////////////////////////////////////////////////
  // helpers

  // one-hot select of a memory module fault indicator
  function automatic logic [DIMM_NUM-1:0] onehot_f(input logic [2:0] idx);
    logic [DIMM_NUM-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // next value of a half-period blink counter
  function automatic logic [31:0] tick_f(input logic [31:0] cnt, input int unsigned half);
    logic [31:0] last;
    last = half - 32'd1;
    if (cnt >= last) begin
      return 32'h0000_0000;
    end
    return cnt + 32'h0000_0001;
  endfunction

  // severity of the present health picture
  function automatic sl_led_e sev_f(input sl_health_s h, input sl_cfg_s c);
    logic fatal;
    logic crit;
    logic degr;
    logic mem_red;
    mem_red = c.spare_en | c.mirror_en;
    // fatal, system failed or shut down
    fatal = h.processor_catastrophic_error
          | h.processor_identity_mismatch
          | h.cpu1_absent
          | h.thermal_trip_flag
          | ~h.power_good
          | (h.dimm_failed & (h.dimm_count == `SL_ONLY_DIMM))
          | (h.mem_uncorrectable & ~mem_red)
          | h.mem_thermal_trip
          | h.south_bridge_thermal_trip
          | h.processor_second_error
          | h.bmc_video_mem_fail
          | h.fw_images_bad
          | h.va240_fault;
    // non-fatal alarm, likely to fail
    crit  = (|h.crit_thresh)
          | h.regulator_hot_flag
          | (h.fans_ok < c.fan_min)
          | h.drive_fault
          | h.pu_insufficient
          | (h.ce_over_thresh & ~mem_red);
    // degraded operation
    degr  = (h.psu_redund_lost & c.psu_redund)
          | (h.fan_redund_lost & c.fan_redund)
          | (h.fan_fault & (h.fans_ok > c.fan_min))
          | (|h.noncrit_thresh)
          | (h.psu_predictive & c.psu_redund)
          | h.battery_fail
          | (h.mem_unusable & (h.dimm_count > `SL_MIN_DIMMS))
          | (h.ce_spare_migrated & c.spare_en)
          | (h.mirror_lost & c.mirror_en)
          | h.bmc_bootloader
          | h.bmc_os_boot
          | ~h.bmc_ready
          | h.bmc_wdt_reset
          | h.pu_config_err
          | h.drive_hot_swap_controller_degraded;
    // most severe wins, no mains means off
    if (!h.ac_present) begin
      return st_off;
    end
    if (fatal) begin
      return st_amber;
    end
    if (crit) begin
      return st_amber_blink;
    end
    if (degr) begin
      return st_green_blink;
    end
    return st_green;
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state

  // blink timers, register port, indicator decisions
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;
    st_next.armed = 1'b1;                         // low only during reset and in the cycle after it
    // free-running blink timers
    st_next.slow_cnt = tick_f(st_reg.slow_cnt, SLOW_HALF);
    st_next.fast_cnt = tick_f(st_reg.fast_cnt, FAST_HALF);
    if (st_next.slow_cnt == 32'h0000_0000) begin
      st_next.slow_ph = ~st_reg.slow_ph;
    end
    if (st_next.fast_cnt == 32'h0000_0000) begin
      st_next.fast_ph = ~st_reg.fast_ph;
    end
    // register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        `SL_OFS_CFG: begin
          st_next.cfg = bus_i.wdata[`SL_CFG_MSB:`SL_CFG_LSB];
        end
        `SL_OFS_POST: begin
          st_next.post = bus_i.wdata[`SL_POST_MSB:`SL_POST_LSB];
        end
        default: begin
        end
      endcase
    end
    // register reads, data stands one cycle
    if (bus_i.rd) begin
      case (bus_i.addr)
        `SL_OFS_CFG: begin
          st_next.rdata[`SL_CFG_MSB:`SL_CFG_LSB] = st_reg.cfg;
        end
        `SL_OFS_POST: begin
          st_next.rdata[`SL_POST_MSB:`SL_POST_LSB] = st_reg.post;
        end
        `SL_OFS_STAT: begin
          st_next.rdata[`SL_STAT_LED_MSB:`SL_STAT_LED_LSB] = st_reg.led;
          st_next.rdata[`SL_STAT_ID_POS] = st_reg.id_on;
          st_next.rdata[`SL_STAT_GRN_POS] = st_reg.green;
          st_next.rdata[`SL_STAT_AMB_POS] = st_reg.amber;
        end
        default: begin
        end
      endcase
    end
    // status indicator state and colour drive
    st_next.led = sev_f(health_i, st_reg.cfg);
    case (st_next.led)
      st_green: begin
        st_next.green = 1'b1;
        st_next.amber = 1'b0;
      end
      st_green_blink: begin
        st_next.green = st_next.slow_ph;
        st_next.amber = 1'b0;
      end
      st_amber_blink: begin
        st_next.green = 1'b0;
        st_next.amber = st_next.slow_ph;
      end
      st_amber: begin
        st_next.green = 1'b0;
        st_next.amber = 1'b1;
      end
      default: begin
        st_next.green = 1'b0;
        st_next.amber = 1'b0;
      end
    endcase
    // identify indicator follows controller stage
    if (health_i.bmc_video_mem_fail | health_i.fw_images_bad) begin
      st_next.id = id_solid;
    end else if (health_i.bmc_bootloader) begin
      st_next.id = id_blink;
    end else if (health_i.bmc_os_boot) begin
      st_next.id = id_solid;
    end else begin
      st_next.id = id_off;
    end
    case (st_next.id)
      id_blink: begin
        st_next.id_on = st_next.fast_ph;
      end
      id_solid: begin
        st_next.id_on = 1'b1;
      end
      default: begin
        st_next.id_on = 1'b0;
      end
    endcase
    // memory module fault indicator on spare migration
    if (health_i.ce_spare_migrated) begin
      st_next.dimm = onehot_f(health_i.spare_dimm);
    end else begin
      st_next.dimm = '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register

  // synchronous active-low reset
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.cfg <= `SL_CFG_RST;
      st_reg.post <= `SL_POST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  // all indicators and read data come from the state register
  assign status_green_o = st_reg.green;
  assign status_amber_o = st_reg.amber;
  assign id_led_o       = st_reg.id_on;
  assign post_leds_o    = st_reg.post;
  assign dimm_fault_o   = st_reg.dimm;
  assign rdata_o        = st_reg.rdata;

  ////////////////////////////////////////////////////////////////
  // checks

  // checks rest in reset and on the release edge, whose response is still the reset state
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i || !st_reg.armed);

  // no mains, indicator dark
  chk_off_no_ac: assert property (
    !health_i.ac_present |=> !status_green_o && !status_amber_o)
    else $error("indicator lit without mains power");

  // steady green only when healthy and booted
  chk_green_solid: assert property (
    st_reg.led == st_green |-> status_green_o && !status_amber_o
      && $past(health_i.ac_present && health_i.bmc_ready && health_i.power_good))
    else $error("steady green without healthy platform");

  // processor catastrophic error gives steady amber
  chk_fatal_amber: assert property (
    health_i.ac_present && health_i.processor_catastrophic_error
      |=> st_reg.led == st_amber && status_amber_o && !status_green_o)
    else $error("catastrophic error not steady amber");

  // fatal outranks a critical threshold
  chk_sev_order: assert property (
    health_i.ac_present && (|health_i.crit_thresh) && !health_i.power_good
      |=> st_reg.led == st_amber)
    else $error("lower severity shown over fatal");

  // critical threshold gives at least amber blink
  chk_crit_blink: assert property (
    health_i.ac_present && (|health_i.crit_thresh)
      |=> st_reg.led inside {st_amber_blink, st_amber} && !status_green_o)
    else $error("critical threshold not amber");

  // too few working fans is an alarm
  chk_fan_min: assert property (
    health_i.ac_present && health_i.fans_ok < st_reg.cfg.fan_min
      |=> st_reg.led >= st_amber_blink)
    else $error("fan shortage not signalled");

  // configured supply redundancy loss is degraded
  chk_psu_redund: assert property (
    health_i.ac_present && st_reg.cfg.psu_redund && health_i.psu_redund_lost
      |=> st_reg.led >= st_green_blink)
    else $error("supply redundancy loss not degraded");

  // green blink follows the slow phase, never amber
  chk_green_blink: assert property (
    st_reg.led == st_green_blink |-> !status_amber_o && status_green_o == st_reg.slow_ph)
    else $error("green blink drive wrong");

  // bootloader stage blinks identify, degraded status
  chk_boot_id: assert property (
    health_i.ac_present && health_i.power_good && health_i.bmc_bootloader
      && !health_i.bmc_video_mem_fail && !health_i.fw_images_bad
      |=> st_reg.id == id_blink && id_led_o == st_reg.fast_ph && st_reg.led >= st_green_blink)
    else $error("bootloader stage indication wrong");

  // controller firmware failure: steady amber, identify on
  chk_fw_fail: assert property (
    health_i.ac_present && health_i.fw_images_bad
      |=> st_reg.led == st_amber && id_led_o)
    else $error("firmware failure indication wrong");

  // progress code write shows on the display
  chk_post_wr: assert property (
    bus_i.wr && bus_i.addr == `SL_OFS_POST
      |=> post_leds_o == $past(bus_i.wdata[7:0]))
    else $error("progress code not displayed");

  // progress code held without a write
  chk_post_hold: assert property (
    !(bus_i.wr && bus_i.addr == `SL_OFS_POST) |=> $stable(post_leds_o))
    else $error("progress code changed without write");

  // spare migration lights the affected module
  chk_dimm_led: assert property (
    health_i.ce_spare_migrated
      |=> dimm_fault_o == onehot_f($past(health_i.spare_dimm)))
    else $error("module fault indicator wrong");

  // supply shortage is an alarm
  chk_pu_short: assert property (
    health_i.ac_present && health_i.pu_insufficient
      |=> st_reg.led >= st_amber_blink)
    else $error("supply shortage not signalled");

  // controller watchdog reset is degraded
  chk_wdt_degr: assert property (
    health_i.ac_present && health_i.bmc_wdt_reset
      |=> st_reg.led >= st_green_blink)
    else $error("watchdog reset not degraded");

  // controller OS boot holds identify steadily on
  chk_id_solid: assert property (
    health_i.bmc_os_boot && !health_i.bmc_bootloader |=> id_led_o)
    else $error("identify not steady during OS boot");

endmodule

// ### sl_plat_model.sv
// platform model: health sources and boot firmware on the register port
// assumes sl_pkg is compiled first and read data stands one cycle after a read
module sl_plat_model
  import sl_pkg::*;
(
  // clock
  input  wire logic          core_clk_i,
  // register port toward the block
  output sl_pkg::sl_bus_s    bus_o,
  input  wire logic [31:0]   rdata_i,
  // health levels toward the block
  output sl_pkg::sl_health_s health_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus and blank health at time zero
  initial begin
    bus_o    = '0;
    health_o = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // firmware posts a code or setting; released lines carry inverted junk
  task automatic fw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_o.addr  <= a;
    bus_o.wdata <= d;
    bus_o.wr    <= 1'h1;
    @(posedge core_clk_i);
    bus_o.wr    <= 1'h0;
    bus_o.addr  <= ~a;
    bus_o.wdata <= ~d;
  endtask

  // firmware read: data taken in the cycle after the strobe
  task automatic fw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    bus_o.addr <= a;
    bus_o.rd   <= 1'h1;
    @(posedge core_clk_i);
    bus_o.rd   <= 1'h0;
    bus_o.addr <= ~a;
    #1;
    d = rdata_i;
  endtask

  // sensors change their levels just after an edge
  task automatic set_health(input sl_health_s h);
    @(posedge core_clk_i);
    health_o <= h;
  endtask
endmodule

// ### sl_status_led_test.sv
// self-checking bench for the status indicator and progress code display
// assumes sl_params.svh, sl_pkg and sl_plat_model are compiled before it
`include "sl_params.svh"
module sl_status_led_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sl_pkg::*;

  localparam int unsigned N_WIN = 20;  // window covers a slow and a fast toggle

  logic       core_clk_i = 1'h0;
  logic       nrst_i     = 1'h0;
  sl_bus_s    bus;
  sl_health_s health;
  logic [31:0] rdata;
  logic       green;
  logic       amber;
  logic       id_led;
  logic [7:0] post;
  logic [7:0] dimm_fault;
  int         bad_count   = 0;
  int         check_count = 0;
  int         cyc         = 0;

  // 100 MHz clock
  always #5 core_clk_i = ~core_clk_i;

  sl_plat_model plat (.core_clk_i(core_clk_i), .bus_o(bus), .rdata_i(rdata), .health_o(health));

  sl_status_led #(.SLOW_HALF(8), .FAST_HALF(3), .DIMM_NUM(8)) dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata), .health_i(health),
    .status_green_o(green), .status_amber_o(amber), .id_led_o(id_led), .post_leds_o(post),
    .dimm_fault_o(dimm_fault));

  //////////////////////////////////////////////////////////////////////////////
  // compare, verdict and hang guard
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // cut a hang short well beyond the expected thousand or so cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      end_sim();
    end
  end

  // 0 off, 1 blinking, 2 solid over the window
  function automatic logic [1:0] mode_of(input int ones);
    return ones == 0 ? 2'h0 : (ones == N_WIN ? 2'h2 : 2'h1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset values and an unmapped read
  task automatic reset_test();
    logic [31:0] r;
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    #1 chk("reset outputs", {green, amber, id_led, post, dimm_fault}, 32'h0000_0000);
    plat.fw_read(`SL_OFS_CFG, r);
    chk("cfg reset", r, 32'h0000_0020);
    plat.fw_read(`SL_OFS_POST, r);
    chk("post reset", r, 32'h0000_0000);
    plat.fw_read(8'h0C, r);
    chk("unmapped read", r, 32'h0000_0000);
    $display("reset test done");
  endtask

  // every condition alone, then mixes, judged on the register and the pins
  task automatic status_test();
    sl_health_s  h;
    logic [7:0]  c;
    logic [2:0]  e;
    logic [31:0] st;
    int          g;
    int          a;
    int          d;
    for (int i = 0; i < 40; i++) begin
      h = '0;
      h.ac_present = 1'h1;
      h.bmc_ready  = 1'h1;
      h.power_good = 1'h1;
      h.fans_ok    = 4'h4;
      h.dimm_count = 4'h4;
      c = 8'h2F;
      e = i < 14 ? st_green_blink : (i < 20 ? st_amber_blink : st_amber);
      case (i)
        0: h.psu_redund_lost = 1'h1;
        1: h.fan_redund_lost = 1'h1;
        2: begin h.fan_fault = 1'h1; h.fans_ok = 4'h3; end
        3: h.noncrit_thresh = 5'h10;
        4: h.psu_predictive = 1'h1;
        5: h.battery_fail = 1'h1;
        6: begin h.mem_unusable = 1'h1; h.dimm_count = 4'h2; end
        7: begin h.ce_spare_migrated = 1'h1; h.spare_dimm = 3'h3; end
        8: h.mirror_lost = 1'h1;
        9: h.bmc_bootloader = 1'h1;
        10: h.bmc_os_boot = 1'h1;
        11: h.bmc_wdt_reset = 1'h1;
        12: h.pu_config_err = 1'h1;
        13: h.drive_hot_swap_controller_degraded = 1'h1;
        14: h.crit_thresh = 5'h01;
        15: h.regulator_hot_flag = 1'h1;
        16: h.fans_ok = 4'h1;
        17: h.drive_fault = 1'h1;
        18: h.pu_insufficient = 1'h1;
        19: begin h.ce_over_thresh = 1'h1; c = 8'h20; end
        20: h.processor_catastrophic_error = 1'h1;
        21: h.processor_identity_mismatch = 1'h1;
        22: h.cpu1_absent = 1'h1;
        23: h.thermal_trip_flag = 1'h1;
        24: h.power_good = 1'h0;
        25: begin h.dimm_failed = 1'h1; h.dimm_count = 4'h1; end
        26: begin h.mem_uncorrectable = 1'h1; c = 8'h20; end
        27: h.mem_thermal_trip = 1'h1;
        28: h.south_bridge_thermal_trip = 1'h1;
        29: h.processor_second_error = 1'h1;
        30: h.bmc_video_mem_fail = 1'h1;
        31: h.fw_images_bad = 1'h1;
        32: h.va240_fault = 1'h1;
        33: begin h.crit_thresh = 5'h04; h.processor_catastrophic_error = 1'h1; end
        34: begin h.noncrit_thresh = 5'h01; h.drive_fault = 1'h1; e = st_amber_blink; end
        35: begin h.ac_present = 1'h0; h.processor_catastrophic_error = 1'h1; e = st_off; end
        36: begin h.bmc_ready = 1'h0; e = st_green_blink; end
        37: begin h.psu_redund_lost = 1'h1; c = 8'h20; e = st_green; end
        38: begin h.mem_unusable = 1'h1; h.dimm_count = 4'h1; e = st_green; end
        default: e = st_green;
      endcase
      plat.fw_write(`SL_OFS_CFG, {24'h00_0000, c});
      plat.set_health(h);
      plat.fw_read(`SL_OFS_STAT, st);
      chk("led state", {29'h0, st[2:0]}, {29'h0, e});
      g = 0;
      a = 0;
      d = 0;
      repeat (N_WIN) begin
        @(posedge core_clk_i);
        #1;
        g += int'(green);
        a += int'(amber);
        d += int'(id_led);
      end
      chk("green", mode_of(g), e == st_green ? 2'h2 : (e == st_green_blink ? 2'h1 : 2'h0));
      chk("amber", mode_of(a), e == st_amber ? 2'h2 : (e == st_amber_blink ? 2'h1 : 2'h0));
      chk("identify", mode_of(d), i == 9 ? 2'h1 : (i inside {10, 30, 31} ? 2'h2 : 2'h0));
      chk("dimm fault", dimm_fault, i == 7 ? 8'h08 : 8'h00);
    end
    $display("status test done");
  endtask

  // progress code: bit order, holding, refused writes, reset in mid-run
  task automatic post_test();
    sl_health_s  h;
    logic [31:0] r;
    plat.fw_write(`SL_OFS_POST, 32'h0000_00A5);
    #1 chk("post leds", post, 8'hA5);
    plat.fw_write(`SL_OFS_POST, 32'h0000_0080);
    #1 chk("post msb", post, 8'h80);
    plat.fw_write(`SL_OFS_POST, 32'h0000_0001);
    #1 chk("post lsb", post, 8'h01);
    h = '0;
    h.ac_present = 1'h1;
    h.power_good = 1'h1;
    h.bmc_ready  = 1'h1;
    h.processor_catastrophic_error = 1'h1;
    plat.set_health(h);
    plat.fw_write(`SL_OFS_CFG, 32'h0000_005A);
    plat.fw_write(`SL_OFS_STAT, 32'hFFFF_FFFF);
    plat.fw_write(8'h0C, 32'hFFFF_FFFF);
    repeat (30) @(posedge core_clk_i);
    #1 chk("post held", post, 8'h01);
    plat.fw_read(`SL_OFS_STAT, r);
    chk("stat read only", r, 32'h0000_0024);
    @(posedge core_clk_i);
    #1 chk("read data drops", rdata, 32'h0000_0000);
    plat.fw_read(`SL_OFS_CFG, r);
    chk("cfg kept", r, 32'h0000_005A);
    plat.fw_read(`SL_OFS_POST, r);
    chk("post readback", r, 32'h0000_0001);
    @(posedge core_clk_i);
    nrst_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    #1 chk("post after reset", {amber, post}, 9'h000);
    @(posedge core_clk_i);
    nrst_i <= 1'h1;
    plat.fw_read(`SL_OFS_CFG, r);
    chk("cfg after reset", r, 32'h0000_0020);
    $display("post test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_test();
    status_test();
    post_test();
    end_sim();
  end
endmodule
